/* verilog/lane_map_pkg.sv */
package lane_map_pkg;

    // Link mode codes
    localparam logic [5:0] MODE_SC_DEC8_WIDE = 6'h1b; // 27
    localparam logic [5:0] MODE_SC_12BIT     = 6'h20; // 32
    localparam logic [5:0] MODE_DC_12BIT     = 6'h21; // 33
    localparam logic [5:0] MODE_SC_8BIT      = 6'h22; // 34
    localparam logic [5:0] MODE_DC_8BIT      = 6'h23; // 35
    localparam logic [5:0] MODE_DC_DEC4      = 6'h25; // 37
    localparam logic [5:0] MODE_SC_DEC8      = 6'h26; // 38
    localparam logic [5:0] MODE_DC_DEC8      = 6'h27; // 39
    localparam logic [5:0] MODE_SC_ALIAS_A   = 6'h36; // 54
    localparam logic [5:0] MODE_DC_DEC16     = 6'h38; // 56
    localparam logic [5:0] MODE_SC_ALIAS_B   = 6'h3f; // 63

    // Geometry
    localparam int LANES_PER_LINK = 8;
    localparam int LANE_COUNT     = 16;
    localparam int LINK_B_BASE    = 8;
    localparam int RAW_BITS       = 12;
    localparam int COMP_BITS      = 15;
    localparam int LANE_BITS      = 32;
    localparam int FIFO_DEPTH     = 16;

    // Frame clock divider: 125 MHz core to frame rate
    localparam int FRAME_DIV      = 4;

    // Octets carried per lane per frame
    localparam logic [2:0] OCTETS_NONE = 3'h0;
    localparam logic [2:0] OCTETS_ONE  = 3'h1;
    localparam logic [2:0] OCTETS_TWO  = 3'h2;
    localparam logic [2:0] OCTETS_FOUR = 3'h4;

    // Reset values
    localparam logic [5:0]  MODE_RESET      = MODE_SC_DEC8_WIDE;
    localparam logic [15:0] LANE_EN_RESET   = 16'h0000;

    typedef struct packed {
        logic [7:0][RAW_BITS-1:0]   raw;   // undecimated samples
        logic [15:0][COMP_BITS-1:0] comp;  // decimated I/Q components
    } sample_frame_t;

    typedef struct packed {
        logic [LANE_COUNT-1:0][LANE_BITS-1:0] data;   // octet 0 in top byte
        logic [LANE_COUNT-1:0]                enable;
        logic [2:0]                           octets;
    } lane_frame_t;

endpackage

/* verilog/frame_fifo.sv */
`timescale 1ns/10ps
module frame_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop_mem;
    logic             out_valid_q;
    logic [WIDTH-1:0] out_data_q;

    assign in_ready  = (count_q != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    // Refill the output register whenever it is empty or being drained
    assign pop_mem   = (count_q != '0) && (!out_valid_q || out_ready);
    assign out_valid = out_valid_q;
    assign out_data  = out_data_q;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop_mem) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop_mem);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else if (pop_mem) begin
            out_valid_q <= 1'b1;
            out_data_q  <= mem[rd_ptr_q];
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

endmodule

/* verilog/transport_lane_octet_mapper.sv */
// Function
// RULE_01 - Mode 27: sixteen lanes, A lane k is I word k, B is Q word k.
// RULE_02 - Modes 54 and 63 reuse the mode 27 per-lane word arrangement.
// RULE_03 - Mode 32: 12-bit samples, three lanes per link, even on A, odd on B.
// RULE_04 - Mode 32 packing runs contiguously: 12 bits, then next sample split across lanes.
// RULE_05 - Mode 33: channel A samples 0-3 on link A, channel B on link B.
// RULE_06 - Mode 34: 8-bit samples 0,2 on A lanes 0,1; 1,3 on B.
// RULE_07 - Mode 35: 8-bit channel A samples on link A, channel B on link B.
// RULE_08 - Mode 37: lane 0 I word with first flag, lane 1 Q with second.
// RULE_09 - Mode 38: lane 0 only; link A I word, link B Q word.
// RULE_10 - Mode 39: lane 0 four octets, I word first then Q word.
// RULE_11 - Mode 56: same four-octet lane 0 layout, channel A on A, B on B.
// RULE_12 - Decimated words are 16 bits; undecimated samples are 12-bit packed.
// RULE_13 - Samples go MSB first; unused tail bits are zero.
// RULE_14 - Use lowest lanes of each link; higher lanes are powered down.
// RULE_15 - Flags rise when a component exceeds its programmed threshold.
// RULE_16 - Decimated word: 15 data bits on top, flag in bit 0.
`timescale 1ns/10ps
module transport_lane_octet_mapper
    import lane_map_pkg::*;
#(
    parameter int FIFO_WIDTH = $bits(sample_frame_t),
    parameter int FIFO_WORDS = FIFO_DEPTH,
    parameter int DIVIDE     = FRAME_DIV
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Configuration
    input  wire logic [5:0]           link_mode_select,
    input  wire logic [COMP_BITS-1:0] overrange_threshold_first,
    input  wire logic [COMP_BITS-1:0] overrange_threshold_second,
    // Sample input
    input  wire logic                 sample_valid,
    output logic                      sample_ready,
    input  wire sample_frame_t        sample_frame,
    // Lane output
    output lane_frame_t               lane_frame,
    output logic                      frame_valid,
    output logic                      frame_underrun
);

    sample_frame_t fifo_data;
    logic          fifo_valid;
    logic          frame_tick;
    logic [$clog2(DIVIDE+1)-1:0] div_q;
    logic [5:0]    mode_q;
    lane_frame_t   map_d;
    lane_frame_t   lane_q;
    logic          frame_valid_q;
    logic          underrun_q;

    frame_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (sample_frame),
        .out_valid (fifo_valid),
        .out_ready (frame_tick),
        .out_data  (fifo_data)
    );

    // Absolute value of a two's complement component against a threshold
    function automatic logic over_thr(input logic [COMP_BITS-1:0] c,
                                      input logic [COMP_BITS-1:0] thr);
        logic [COMP_BITS-1:0] mag;
        mag = c[COMP_BITS-1] ? (~c + COMP_BITS'(1)) : c;
        return mag > thr; // RULE_15
    endfunction

    // 16-bit decimated word: 15 data bits on top, flag in bit 0
    function automatic logic [15:0] word16(input logic [COMP_BITS-1:0] c,
                                           input logic [COMP_BITS-1:0] thr);
        return {c, over_thr(c, thr)}; // RULE_16
    endfunction

    // 16-bit decimated word, left-justified in a lane
    function automatic logic [LANE_BITS-1:0] dec_word(input logic [COMP_BITS-1:0] c,
                                                      input logic [COMP_BITS-1:0] thr);
        return {word16(c, thr), 16'h0000}; // RULE_16 RULE_12 RULE_13
    endfunction

    // Four 12-bit samples packed MSB first over three 16-bit lanes
    function automatic logic [47:0] pack12(input logic [RAW_BITS-1:0] s0,
                                           input logic [RAW_BITS-1:0] s1,
                                           input logic [RAW_BITS-1:0] s2,
                                           input logic [RAW_BITS-1:0] s3);
        return {s0, s1, s2, s3}; // RULE_04 RULE_12
    endfunction

    // Frame rate enable from the core clock
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_q <= '0;
        end else if (div_q == ($clog2(DIVIDE+1))'(DIVIDE-1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + ($clog2(DIVIDE+1))'(1);
        end
    end
    assign frame_tick = (div_q == ($clog2(DIVIDE+1))'(DIVIDE-1));

    // Mode changes only take effect on a frame boundary
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_q <= MODE_RESET;
        end else if (frame_tick) begin
            mode_q <= link_mode_select;
        end
    end

    always_comb begin
        logic [47:0] pa;
        logic [47:0] pb;
        pa = '0;
        pb = '0;
        map_d.data   = '0; // RULE_13
        map_d.enable = LANE_EN_RESET;
        map_d.octets = OCTETS_NONE;
        case (mode_q)
            MODE_SC_DEC8_WIDE, MODE_SC_ALIAS_A, MODE_SC_ALIAS_B: begin
                map_d.octets = OCTETS_TWO;
                map_d.enable = 16'hffff; // RULE_01
                for (int k = 0; k < LANES_PER_LINK; k++) begin
                    map_d.data[k] = dec_word(fifo_data.comp[k],
                                             overrange_threshold_first); // RULE_01 RULE_02
                    map_d.data[LINK_B_BASE+k] = dec_word(fifo_data.comp[8+k],
                                                         overrange_threshold_second);
                end
            end
            MODE_SC_12BIT, MODE_DC_12BIT: begin
                map_d.octets = OCTETS_TWO;
                map_d.enable = 16'h0707; // RULE_14
                if (mode_q == MODE_SC_12BIT) begin
                    pa = pack12(fifo_data.raw[0], fifo_data.raw[2],
                                fifo_data.raw[4], fifo_data.raw[6]); // RULE_03
                    pb = pack12(fifo_data.raw[1], fifo_data.raw[3],
                                fifo_data.raw[5], fifo_data.raw[7]);
                end else begin
                    pa = pack12(fifo_data.raw[0], fifo_data.raw[1],
                                fifo_data.raw[2], fifo_data.raw[3]); // RULE_05
                    pb = pack12(fifo_data.raw[4], fifo_data.raw[5],
                                fifo_data.raw[6], fifo_data.raw[7]);
                end
                for (int k = 0; k < 3; k++) begin
                    map_d.data[k]             = {pa[47-16*k -: 16], 16'h0000};
                    map_d.data[LINK_B_BASE+k] = {pb[47-16*k -: 16], 16'h0000};
                end
            end
            MODE_SC_8BIT: begin
                map_d.octets = OCTETS_ONE;
                map_d.enable = 16'h0303;
                map_d.data[0] = {fifo_data.raw[0][11:4], 24'h000000}; // RULE_06
                map_d.data[1] = {fifo_data.raw[2][11:4], 24'h000000};
                map_d.data[LINK_B_BASE]   = {fifo_data.raw[1][11:4], 24'h000000};
                map_d.data[LINK_B_BASE+1] = {fifo_data.raw[3][11:4], 24'h000000};
            end
            MODE_DC_8BIT: begin
                map_d.octets = OCTETS_ONE;
                map_d.enable = 16'h0303;
                map_d.data[0] = {fifo_data.raw[0][11:4], 24'h000000}; // RULE_07
                map_d.data[1] = {fifo_data.raw[1][11:4], 24'h000000};
                map_d.data[LINK_B_BASE]   = {fifo_data.raw[4][11:4], 24'h000000};
                map_d.data[LINK_B_BASE+1] = {fifo_data.raw[5][11:4], 24'h000000};
            end
            MODE_DC_DEC4: begin
                map_d.octets = OCTETS_TWO;
                map_d.enable = 16'h0303;
                map_d.data[0] = dec_word(fifo_data.comp[0], overrange_threshold_first); // RULE_08
                map_d.data[1] = dec_word(fifo_data.comp[1], overrange_threshold_second);
                map_d.data[LINK_B_BASE]   = dec_word(fifo_data.comp[2],
                                                     overrange_threshold_first);
                map_d.data[LINK_B_BASE+1] = dec_word(fifo_data.comp[3],
                                                     overrange_threshold_second);
            end
            MODE_SC_DEC8: begin
                map_d.octets = OCTETS_TWO;
                map_d.enable = 16'h0101; // RULE_09
                map_d.data[0] = dec_word(fifo_data.comp[0], overrange_threshold_first);
                map_d.data[LINK_B_BASE] = dec_word(fifo_data.comp[1],
                                                   overrange_threshold_second);
            end
            MODE_DC_DEC8, MODE_DC_DEC16: begin
                map_d.octets = OCTETS_FOUR;
                map_d.enable = 16'h0101;
                map_d.data[0] = {word16(fifo_data.comp[0], overrange_threshold_first), // RULE_10
                                 word16(fifo_data.comp[1], overrange_threshold_second)};
                map_d.data[LINK_B_BASE] =
                    {word16(fifo_data.comp[2], overrange_threshold_first), // RULE_11
                     word16(fifo_data.comp[3], overrange_threshold_second)};
            end
            default: begin
                // Unsupported code: every lane stays powered down
                map_d.octets = OCTETS_NONE;
            end
        endcase
    end

    // Lane register; a starved frame sends zeros rather than stale data
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lane_q <= '0;
        end else if (frame_tick) begin
            lane_q.data   <= fifo_valid ? map_d.data : '0;
            lane_q.enable <= map_d.enable;
            lane_q.octets <= map_d.octets;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            frame_valid_q <= 1'b0;
            underrun_q    <= 1'b0;
        end else begin
            frame_valid_q <= frame_tick;
            underrun_q    <= frame_tick && !fifo_valid;
        end
    end

    assign lane_frame     = lane_q;
    assign frame_valid    = frame_valid_q;
    assign frame_underrun = underrun_q;

endmodule

/* tb/mapper_chk.sv */
`timescale 1ns/10ps
module mapper_chk
    import lane_map_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // Watched outputs
    input wire logic        sample_ready,
    input wire lane_frame_t lane_frame,
    input wire logic        frame_valid,
    input wire logic        frame_underrun
);
    logic off_bits;
    logic tail_bits;
    always_comb begin
        off_bits  = 1'b0;
        tail_bits = 1'b0;
        for (int i = 0; i < LANE_COUNT; i++) begin
            off_bits = off_bits | (!lane_frame.enable[i] && |lane_frame.data[i]);
            if (lane_frame.octets == OCTETS_ONE)
                tail_bits = tail_bits | (|lane_frame.data[i][23:0]);
            if (lane_frame.octets == OCTETS_TWO)
                tail_bits = tail_bits | (|lane_frame.data[i][15:0]);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    frame_period_a: assert property (frame_valid |=> !frame_valid [*3] ##1 frame_valid)
        else $error("frame pulse spacing wrong");
    underrun_pulse_a: assert property (frame_underrun |-> frame_valid)
        else $error("underrun without frame");
    underrun_zero_a: assert property (frame_underrun |-> lane_frame.data == '0)
        else $error("underrun frame carries data");
    lane_hold_a: assert property (!frame_valid |-> $stable(lane_frame))
        else $error("lanes changed between frames");
    off_lane_a: assert property (!off_bits)
        else $error("disabled lane carries data");
    tail_zero_a: assert property (!tail_bits)
        else $error("unused octets not zero");
    lane_shape_a: assert property (lane_frame.enable[7:0] == lane_frame.enable[15:8] &&
        (lane_frame.enable[7:0] & (lane_frame.enable[7:0] + 8'h01)) == 8'h00)
        else $error("lane enables not lowest lanes");
    four_octet_a: assert property (
        lane_frame.octets == OCTETS_FOUR |-> lane_frame.enable == 16'h0101)
        else $error("four octets on wrong lanes");
    ready_reset_a: assert property ($fell(reset) |-> sample_ready && !frame_valid)
        else $error("bad state after reset");
    cover property (frame_underrun);
    cover property (!sample_ready);
    cover property (frame_valid && lane_frame.octets == OCTETS_FOUR);
endmodule
bind transport_lane_octet_mapper mapper_chk mapper_chk_i (.core_clk(core_clk), .reset(reset),
    .sample_ready(sample_ready), .lane_frame(lane_frame), .frame_valid(frame_valid),
    .frame_underrun(frame_underrun));

/* tb/lane_rx_model.sv */
`timescale 1ns/10ps
module lane_rx_model
    import lane_map_pkg::*;
(
    // Lane side
    input wire logic        core_clk,
    input wire logic        reset,
    input wire lane_frame_t lane_frame,
    input wire logic        frame_valid,
    input wire logic        frame_underrun
);
    // No back-pressure on the lanes, so the receiver only records
    lane_frame_t got_q[$];
    lane_frame_t idle_q;
    always @(posedge core_clk) begin
        if (!reset && frame_valid) begin
            if (frame_underrun)
                idle_q <= lane_frame;
            else
                got_q.push_back(lane_frame);
        end
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    import lane_map_pkg::*;
    logic                 core_clk, reset, sample_valid, sample_ready, frame_valid, frame_underrun;
    logic [5:0]           mode;
    logic [COMP_BITS-1:0] thr1, thr2;
    logic [31:0]          rng;
    sample_frame_t        sf;
    lane_frame_t          lf;
    sample_frame_t        sent_q[$];
    int                   num_errors, checks_done;
    logic [5:0]           modes[12] = '{6'h1b, 6'h20, 6'h21, 6'h22, 6'h23, 6'h25, 6'h26,
                                        6'h27, 6'h36, 6'h38, 6'h3f, 6'h00};
    transport_lane_octet_mapper transport_lane_octet_mapper_i (.core_clk(core_clk), .reset(reset),
        .link_mode_select(mode), .overrange_threshold_first(thr1),
        .overrange_threshold_second(thr2), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_frame(sf), .lane_frame(lf),
        .frame_valid(frame_valid), .frame_underrun(frame_underrun));
    lane_rx_model lane_rx_model_i (.core_clk(core_clk), .reset(reset), .lane_frame(lf),
        .frame_valid(frame_valid), .frame_underrun(frame_underrun));
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic [15:0] dw(logic [COMP_BITS-1:0] c, logic [COMP_BITS-1:0] t);
        logic [COMP_BITS-1:0] m;
        m = c[COMP_BITS-1] ? -c : c;
        return {c, m > t};
    endfunction
    function automatic lane_frame_t expect_frame(logic [5:0] m, sample_frame_t s);
        lane_frame_t e;
        logic [47:0] pa, pb;
        bit          sc;
        e  = '0;
        sc = (m == MODE_SC_12BIT || m == MODE_SC_8BIT);
        pa = sc ? {s.raw[0], s.raw[2], s.raw[4], s.raw[6]}
                : {s.raw[0], s.raw[1], s.raw[2], s.raw[3]};
        pb = sc ? {s.raw[1], s.raw[3], s.raw[5], s.raw[7]}
                : {s.raw[4], s.raw[5], s.raw[6], s.raw[7]};
        e.enable = 16'h0303;
        e.octets = OCTETS_TWO;
        case (m)
            MODE_SC_DEC8_WIDE, MODE_SC_ALIAS_A, MODE_SC_ALIAS_B: begin
                for (int k = 0; k < 8; k++) begin
                    e.data[k]     = {dw(s.comp[k], thr1), 16'h0000};
                    e.data[8 + k] = {dw(s.comp[8 + k], thr2), 16'h0000};
                end
                e.enable = 16'hffff;
            end
            MODE_SC_12BIT, MODE_DC_12BIT: begin
                for (int k = 0; k < 3; k++) begin
                    e.data[k]     = {pa[47 - 16 * k -: 16], 16'h0000};
                    e.data[8 + k] = {pb[47 - 16 * k -: 16], 16'h0000};
                end
                e.enable = 16'h0707;
            end
            MODE_SC_8BIT, MODE_DC_8BIT: begin
                e.data[0] = {pa[47:40], 24'h000000};
                e.data[1] = {pa[35:28], 24'h000000};
                e.data[8] = {pb[47:40], 24'h000000};
                e.data[9] = {pb[35:28], 24'h000000};
                e.octets  = OCTETS_ONE;
            end
            MODE_DC_DEC4: begin
                e.data[0] = {dw(s.comp[0], thr1), 16'h0000};
                e.data[1] = {dw(s.comp[1], thr2), 16'h0000};
                e.data[8] = {dw(s.comp[2], thr1), 16'h0000};
                e.data[9] = {dw(s.comp[3], thr2), 16'h0000};
            end
            MODE_SC_DEC8: begin
                e.data[0] = {dw(s.comp[0], thr1), 16'h0000};
                e.data[8] = {dw(s.comp[1], thr2), 16'h0000};
                e.enable  = 16'h0101;
            end
            MODE_DC_DEC8, MODE_DC_DEC16: begin
                e.data[0] = {dw(s.comp[0], thr1), dw(s.comp[1], thr2)};
                e.data[8] = {dw(s.comp[2], thr1), dw(s.comp[3], thr2)};
                e.enable  = 16'h0101;
                e.octets  = OCTETS_FOUR;
            end
            default: e = '0;
        endcase
        return e;
    endfunction
    task automatic err(string msg);
        num_errors++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wait_cond(int kind, int n);
        int c;
        c = 0;
        while (n > 0 && c < 2000) begin
            @(negedge core_clk);
            c++;
            if (kind == 0 && frame_valid === 1'b1)
                n--;
            if (kind == 1 && lane_rx_model_i.got_q.size() >= sent_q.size())
                n = 0;
        end
        @(posedge core_clk);
        #1;
        if (n > 0) begin
            err("wait ran out");
            final_report();
        end
    endtask
    task automatic push(int n, bit fill);
        bit took;
        for (int w = 0; w < 21; w++)
            sf[16 * w +: 16] = 16'(xs());
        sf.comp[0] = thr1;
        sf.comp[1] = -(thr2 + 15'h0001);
        sample_valid = 1'b1;
        for (int c = 0; c < 2000 && n > 0; c++) begin
            @(negedge core_clk);
            took = (sample_ready === 1'b1);
            @(posedge core_clk);
            #1;
            n = took ? n - 1 : (fill ? 0 : n);
            if (took)
                sent_q.push_back(sf);
            for (int w = 0; w < 21 && took; w++)
                sf[16 * w +: 16] = 16'(xs());
        end
        sample_valid = 1'b0;
        if (n > 0) begin
            err("sample input stalled");
            final_report();
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {num_errors, checks_done} = '0;
        rng = 32'd92;
        {sample_valid, mode, thr1, thr2, sf} = '0;
        reset = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        reset = 1'b0;
        foreach (modes[i]) begin
            mode = modes[i];
            thr1 = 15'(xs() & 32'h00003fff);
            thr2 = 15'(xs() & 32'h00003fff);
            wait_cond(0, 3);
            checks_done++;
            if (lane_rx_model_i.idle_q !== expect_frame(mode, '0)) err("idle layout");
            lane_rx_model_i.got_q.delete();
            sent_q.delete();
            push(i == 0 ? 40 : 5, i == 0);
            checks_done++;
            if (i == 0 && sent_q.size() < 17) err("buffer refused early");
            wait_cond(1, 1);
            foreach (sent_q[j]) begin
                checks_done++;
                if (lane_rx_model_i.got_q[j] !== expect_frame(mode, sent_q[j])) err("lane data");
            end
            $display("Mode %0d finished, %0d frames", mode, sent_q.size());
        end
        final_report();
    end
endmodule
